// ===== design/flash_cfg_device.sv
// Flash end: volatile, enhanced volatile and nonvolatile configuration.
`timescale 1ns/100ps
module flash_cfg_device #(
  parameter logic [3:0] DEFAULT_DUMMY = 4'hA,
  parameter bit FORCED_XIP = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  flash_link_if.dev link,
  input wire logic power_cycle,
  output logic [23:0] mem_addr,
  input wire logic [7:0] mem_data,
  output flash_cfg_pkg::protocol_t protocol,
  output logic [3:0] dummy_cycles,
  output logic execute_in_place,
  output logic [1:0] wrap_code,
  output logic hold_reset_en,
  output logic vpp_accel_en,
  output logic [2:0] drive_strength
);
  import flash_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA_OUT = 3'h6,
    ST_DATA_IN = 3'h7,
    ST_IGNORE = 3'h5
  } state_t;

  typedef enum logic [1:0] {
    K_VCR = 2'h0,
    K_EVCR = 2'h1,
    K_NV = 2'h2,
    K_MEM = 2'h3
  } kind_t;

  logic s_sclk;
  logic s_cs_n;
  logic s_mosi;
  logic sclk_q;
  logic rise;
  logic fall;
  state_t state, next_state;
  kind_t kind, next_kind;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [23:0] in_sr, next_in_sr;
  logic [7:0] out_sr, next_out_sr;
  logic reload, next_reload;
  logic byte_sel, next_byte_sel;
  logic [23:0] next_mem_addr;
  logic [7:0] vcr, next_vcr;
  logic [7:0] evcr, next_evcr;
  logic [15:0] nvcr, next_nvcr;
  logic xip_latched, next_xip_latched;
  logic [7:0] in_byte;
  logic [7:0] out_byte;

  // Pins from the host cross into this clock through two flops.
  pin_sync #(
    .WIDTH(3),
    .INIT(3'h2)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .d({link.sclk, link.cs_n, link.mosi}),
    .q({s_sclk, s_cs_n, s_mosi})
  );

  assign rise = s_sclk & ~sclk_q;
  assign fall = ~s_sclk & sclk_q;
  assign in_byte = {in_sr[6:0], s_mosi};
  assign link.miso = out_sr[7];

  // Aligned-block wrap, or plain increment for the sequential code.
  function automatic logic [23:0] next_address(input logic [23:0] a,
                                              input logic [1:0] w);
    logic [23:0] m;
    m = 24'h00000F;
    unique case (w)
      2'h0: m = 24'h00000F;
      2'h1: m = 24'h00001F;
      2'h2: m = 24'h00003F;
      2'h3: m = 24'h000000;
    endcase
    if (w == WRAP_SEQUENTIAL) begin
      next_address = a + 24'h000001;
    end else begin
      next_address = (a & ~m) | ((a + 24'h000001) & m);
    end
  endfunction

  // Decoded settings; every one follows the stored bits immediately.
  always_comb begin
    if (vcr[7:4] == DUMMY_CODE_LOW || vcr[7:4] == DUMMY_CODE_HIGH) begin
      dummy_cycles = DEFAULT_DUMMY;
    end else begin
      dummy_cycles = vcr[VCR_DUMMY_LSB +: 4];
    end
    execute_in_place = FORCED_XIP | ~vcr[VCR_XIP_BIT];
    wrap_code = vcr[1:0];
    if (!evcr[EVCR_QUAD_BIT]) begin
      protocol = PROTO_QUAD;
    end else if (!evcr[EVCR_DUAL_BIT]) begin
      protocol = PROTO_DUAL;
    end else begin
      protocol = PROTO_EXTENDED;
    end
    hold_reset_en = evcr[EVCR_HOLD_BIT];
    vpp_accel_en = ~evcr[EVCR_VPP_BIT];
    drive_strength = evcr[2:0];
  end

  // Byte that the next falling edge puts on the output.
  always_comb begin
    unique case (kind)
      K_VCR: out_byte = vcr;
      K_EVCR: out_byte = evcr;
      K_NV: out_byte = byte_sel ? nvcr[7:0] : nvcr[15:8];
      K_MEM: out_byte = mem_data;
    endcase
  end

  // Frame sequencer: bits in on rising edges, bits out on falling edges.
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_bit_cnt = bit_cnt;
    next_in_sr = in_sr;
    next_out_sr = out_sr;
    next_reload = reload;
    next_byte_sel = byte_sel;
    next_mem_addr = mem_addr;
    next_vcr = vcr;
    next_evcr = evcr;
    next_nvcr = nvcr;
    next_xip_latched = xip_latched;
    if (s_cs_n) begin
      next_state = ST_IDLE;
      next_bit_cnt = 5'h00;
      next_reload = 1'b0;
      next_out_sr = 8'h00; // A refused frame then keeps its output low.
      // An address phase cut short is one way out of execute in place; a power cycle is the other.
      if (state == ST_ADDR && xip_latched) begin
        next_xip_latched = 1'b0;
      end else if (state == ST_DATA_OUT && kind == K_MEM) begin
        next_xip_latched = execute_in_place;
      end
      // A power cycle reloads the volatile copies from nonvolatile bits.
      if (power_cycle) begin
        next_vcr = {nvcr[NV_DUMMY_LSB +: 4], 1'b1, 1'b0, WRAP_SEQUENTIAL};
        next_evcr = {nvcr[NV_QUAD_BIT], nvcr[NV_DUAL_BIT], 1'b0,
                     nvcr[NV_HOLD_BIT], 1'b1, nvcr[NV_DRIVE_LSB +: 3]};
        next_xip_latched = 1'b0;
      end
    end else if (state == ST_IDLE) begin
      next_state = xip_latched ? ST_ADDR : ST_OPCODE;
      next_kind = K_MEM;
    end else if (rise) begin
      next_in_sr = {in_sr[22:0], s_mosi};
      next_bit_cnt = bit_cnt + 5'h01;
      unique case (state)
        ST_OPCODE: begin
          if (bit_cnt == 5'h07) begin
            next_bit_cnt = 5'h00;
            next_reload = 1'b1;
            next_byte_sel = 1'b0;
            next_state = ST_DATA_OUT;
            // Each register answers only to its own pair of codes.
            unique case (in_byte)
              OP_READ_VCR: next_kind = K_VCR;
              OP_READ_EVCR: next_kind = K_EVCR;
              OP_READ_NV: next_kind = K_NV;
              OP_WRITE_VCR: begin
                next_kind = K_VCR;
                next_state = ST_DATA_IN;
                next_reload = 1'b0;
              end
              OP_WRITE_EVCR: begin
                next_kind = K_EVCR;
                next_state = ST_DATA_IN;
                next_reload = 1'b0;
              end
              OP_WRITE_NV: begin
                next_kind = K_NV;
                next_state = ST_DATA_IN;
                next_reload = 1'b0;
              end
              OP_FAST_READ: begin
                next_kind = K_MEM;
                next_state = ST_ADDR;
                next_reload = 1'b0;
              end
              default: begin
                next_state = ST_IGNORE;
                next_reload = 1'b0;
              end
            endcase
          end
        end
        ST_ADDR: begin
          if (bit_cnt == 5'd23) begin
            next_mem_addr = {in_sr[22:0], s_mosi};
            next_bit_cnt = 5'h00;
            next_state = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (bit_cnt == {1'b0, dummy_cycles - 4'h1}) begin
            next_bit_cnt = 5'h00;
            next_reload = 1'b1;
            next_state = ST_DATA_OUT;
          end
        end
        ST_DATA_OUT: begin
          if (bit_cnt == 5'h07) begin
            next_bit_cnt = 5'h00;
            next_reload = 1'b1;
            if (kind == K_MEM) begin
              next_mem_addr = next_address(mem_addr, vcr[1:0]);
            end
          end
        end
        ST_DATA_IN: begin
          // Volatile writes act on the very next cycle; nonvolatile ones wait for a power cycle; reserved bits drop.
          if (bit_cnt == 5'h07 && kind != K_NV) begin
            next_state = ST_IGNORE;
            if (kind == K_VCR) begin
              next_vcr = in_byte & VCR_MASK;
            end else begin
              next_evcr = in_byte & EVCR_MASK;
            end
          end else if (bit_cnt == 5'h0F) begin
            next_state = ST_IGNORE;
            next_nvcr = {in_sr[14:0], s_mosi} & NV_MASK;
          end
        end
        default: next_bit_cnt = bit_cnt;
      endcase
    end else if (fall && state == ST_DATA_OUT) begin
      if (reload) begin
        next_out_sr = out_byte;
        next_reload = 1'b0;
        next_byte_sel = ~byte_sel;
      end else begin
        next_out_sr = {out_sr[6:0], 1'b0};
      end
    end
  end

  // Registers of the sequencer and the configuration.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      state <= ST_IDLE;
      kind <= K_MEM;
      bit_cnt <= 5'h00;
      in_sr <= 24'h000000;
      out_sr <= 8'h00;
      reload <= 1'b0;
      byte_sel <= 1'b0;
      mem_addr <= 24'h000000;
      vcr <= VCR_RESET;
      evcr <= EVCR_RESET;
      nvcr <= NV_RESET;
      xip_latched <= 1'b0;
    end else begin
      sclk_q <= s_sclk;
      state <= next_state;
      kind <= next_kind;
      bit_cnt <= next_bit_cnt;
      in_sr <= next_in_sr;
      out_sr <= next_out_sr;
      reload <= next_reload;
      byte_sel <= next_byte_sel;
      mem_addr <= next_mem_addr;
      vcr <= next_vcr;
      evcr <= next_evcr;
      nvcr <= next_nvcr;
      xip_latched <= next_xip_latched;
    end
  end
endmodule

// ===== design/flash_cfg_pkg.sv
// Shared constants and types for the flash configuration link and both ends.
package flash_cfg_pkg;
  // Command codes carried in the first byte of a frame.
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_READ_NV = 8'hB5;
  localparam logic [7:0] OP_WRITE_NV = 8'hB1;
  localparam logic [7:0] OP_READ_VCR = 8'h85;
  localparam logic [7:0] OP_WRITE_VCR = 8'h81;
  localparam logic [7:0] OP_READ_EVCR = 8'h65;
  localparam logic [7:0] OP_WRITE_EVCR = 8'h61;
  // Values after reset and masks of the implemented (non-reserved) bits.
  localparam logic [7:0] VCR_RESET = 8'hFB;
  localparam logic [7:0] VCR_MASK = 8'hFB;
  localparam logic [7:0] EVCR_RESET = 8'hDF;
  localparam logic [7:0] EVCR_MASK = 8'hDF;
  localparam logic [15:0] NV_RESET = 16'hFFDC;
  localparam logic [15:0] NV_MASK = 16'hFFDC;
  // Field positions.
  localparam int VCR_DUMMY_LSB = 4;
  localparam int VCR_XIP_BIT = 3;
  localparam int EVCR_QUAD_BIT = 7;
  localparam int EVCR_DUAL_BIT = 6;
  localparam int EVCR_HOLD_BIT = 4;
  localparam int EVCR_VPP_BIT = 3;
  localparam int NV_DUMMY_LSB = 12;
  localparam int NV_DRIVE_LSB = 6;
  localparam int NV_HOLD_BIT = 4;
  localparam int NV_QUAD_BIT = 3;
  localparam int NV_DUAL_BIT = 2;
  localparam logic [3:0] DUMMY_CODE_LOW = 4'h0;
  localparam logic [3:0] DUMMY_CODE_HIGH = 4'hF;
  localparam logic [1:0] WRAP_SEQUENTIAL = 2'h3;
  // Host register offsets and command field positions.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_RXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CMD_NOOP_BIT = 8;
  localparam int CMD_TX_LSB = 9;
  localparam int CMD_RX_LSB = 11;
  localparam int CMD_DUMMY_LSB = 14;
  localparam int CMD_WIDTH = 18;
  // Active serial protocol.
  typedef enum logic [1:0] {
    PROTO_EXTENDED = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2
  } protocol_t;
endpackage

// ===== design/flash_link_if.sv
// Serial link between the host controller and the flash end.
`timescale 1ns/100ps
interface flash_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ===== design/pin_sync.sv
// Two-stage synchroniser for pins arriving from the other party.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== design/flash_cfg_host.sv
// Host end: APB command registers driving frames onto the serial link.
`timescale 1ns/100ps
module flash_cfg_host #(
  parameter int CLK_DIV = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  flash_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import flash_cfg_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_RUN = 2'h1,
    H_END = 2'h3
  } hstate_t;

  hstate_t state, next_state;
  logic s_miso;
  logic [7:0] div_cnt, next_div_cnt;
  logic tick;
  logic [CMD_WIDTH-1:0] cmd, next_cmd;
  logic [23:0] txdata, next_txdata;
  logic [31:0] tx_sr, next_tx_sr;
  logic [31:0] rx_sr, next_rx_sr;
  logic [6:0] bit_cnt, next_bit_cnt;
  logic [6:0] total, next_total;
  logic [6:0] rx_start, next_rx_start;
  logic sclk, next_sclk;
  logic cs_n, next_cs_n;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic setup;
  logic access;
  logic [6:0] op_bits;
  logic [6:0] tx_bits;
  logic [6:0] rx_bits;
  logic [6:0] dm_bits;

  pin_sync #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .d(link.miso),
    .q(s_miso)
  );

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.mosi = tx_sr[31];
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign tick = div_cnt == 8'(CLK_DIV - 1);
  assign op_bits = pwdata[CMD_NOOP_BIT] ? 7'd0 : 7'd8;
  assign tx_bits = {2'b00, pwdata[CMD_TX_LSB +: 2], 3'b000};
  assign rx_bits = {1'b0, pwdata[CMD_RX_LSB +: 3], 3'b000};
  assign dm_bits = {3'b000, pwdata[CMD_DUMMY_LSB +: 4]};

  // Read data and error are latched in the setup cycle, so the answer
  // comes from flops in the single access cycle.
  always_comb begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    unique case (paddr)
      REG_CMD: begin
        next_prdata = {{(32 - CMD_WIDTH){1'b0}}, cmd};
        next_pslverr = pwrite & (state != H_IDLE);
      end
      REG_TXDATA: next_prdata = {8'h00, txdata};
      REG_RXDATA: next_prdata = rx_sr;
      REG_STATUS: next_prdata = {31'h0, state != H_IDLE};
      default: next_pslverr = 1'b1;
    endcase
  end

  // Frame engine: one half serial period per divider tick.
  always_comb begin
    next_state = state;
    next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
    next_cmd = cmd;
    next_txdata = txdata;
    next_tx_sr = tx_sr;
    next_rx_sr = rx_sr;
    next_bit_cnt = bit_cnt;
    next_total = total;
    next_rx_start = rx_start;
    next_sclk = sclk;
    next_cs_n = cs_n;
    if (access && pwrite && paddr == REG_TXDATA) begin
      next_txdata = pwdata[23:0];
    end
    unique case (state)
      H_IDLE: begin
        // Software picks the dummy count to suit CLK_DIV and read type.
        if (access && pwrite && paddr == REG_CMD) begin
          next_cmd = pwdata[CMD_WIDTH-1:0];
          next_total = op_bits + tx_bits + dm_bits + rx_bits;
          next_rx_start = op_bits + tx_bits + dm_bits;
          next_tx_sr = pwdata[CMD_NOOP_BIT] ? {txdata, 8'h00}
                                            : {pwdata[7:0], txdata};
          next_bit_cnt = 7'd0;
          next_div_cnt = 8'h00;
          next_cs_n = 1'b0;
          next_state = H_RUN;
        end
      end
      H_RUN: begin
        if (tick && !sclk) begin
          next_sclk = 1'b1;
        end else if (tick) begin
          next_sclk = 1'b0;
          if (bit_cnt >= rx_start) begin
            next_rx_sr = {rx_sr[30:0], s_miso};
          end
          next_tx_sr = {tx_sr[30:0], 1'b0};
          next_bit_cnt = bit_cnt + 7'd1;
          if (bit_cnt + 7'd1 >= total) begin
            next_cs_n = 1'b1;
            next_state = H_END;
          end
        end
      end
      H_END: begin
        // Keeps select high for a half period before the next frame.
        if (tick) begin
          next_state = H_IDLE;
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  // Registers of the engine and the bus answer.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= H_IDLE;
      div_cnt <= 8'h00;
      cmd <= '0;
      txdata <= 24'h000000;
      tx_sr <= 32'h00000000;
      rx_sr <= 32'h00000000;
      bit_cnt <= 7'd0;
      total <= 7'd0;
      rx_start <= 7'd0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      cmd <= next_cmd;
      txdata <= next_txdata;
      tx_sr <= next_tx_sr;
      rx_sr <= next_rx_sr;
      bit_cnt <= next_bit_cnt;
      total <= next_total;
      rx_start <= next_rx_start;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      if (setup) begin
        prdata <= next_prdata;
        pslverr <= next_pslverr;
      end
    end
  end
endmodule

// ===== bench/flash_cfg_monitor.sv
// Checker of the serial link between the host end and the flash end.
`timescale 1ns/100ps
module flash_cfg_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // The host runs with four system cycles in each half serial period.
  sequence high_half;
    sclk [*4];
  endsequence
  sequence low_half;
    !sclk [*4];
  endsequence

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("Serial clock high outside a frame.");
  a_sclk_high_len: assert property ($rose(sclk) |-> high_half ##1 !sclk)
    else $error("Serial clock high phase has the wrong length.");
  a_sclk_low_len: assert property ($fell(sclk) |-> low_half)
    else $error("Serial clock low phase too short.");
  a_frame_lead_in: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("Serial clock rose too soon after frame start.");
  a_first_bit_held: assert property ($fell(cs_n) |=> $stable(mosi) [*3])
    else $error("First command bit changed before it was sampled.");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("Frames closer than one half period.");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("Host data changed while the serial clock was high.");
  a_miso_steady: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("Flash data changed while the serial clock was high.");
endmodule

// ===== bench/testbench.sv
// Self-checking bench joining the host end and the flash end.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  import flash_cfg_pkg::*;
  localparam logic [32:0] M_ERR = 33'h1_0000_0000;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_cycle = 1'b0;
  logic [23:0] mem_addr;
  wire logic [7:0] mem_data;
  protocol_t protocol;
  logic [3:0] dummy_cycles;
  logic execute_in_place;
  logic [1:0] wrap_code;
  logic hold_reset_en;
  logic vpp_accel_en;
  logic [2:0] drive_strength;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h7D05B20E;
  logic [65:0] notes[$];
  logic [65:0] note;
  flash_link_if link ();

  flash_cfg_host #(.CLK_DIV(4)) i_flash_cfg_host (.clock(clock),
    .reset_n(reset_n), .link(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  flash_cfg_device #(.DEFAULT_DUMMY(4'hA), .FORCED_XIP(1'b0))
    i_flash_cfg_device (.clock(clock), .reset_n(reset_n), .link(link),
    .power_cycle(power_cycle), .mem_addr(mem_addr), .mem_data(mem_data),
    .protocol(protocol), .dummy_cycles(dummy_cycles),
    .execute_in_place(execute_in_place), .wrap_code(wrap_code),
    .hold_reset_en(hold_reset_en), .vpp_accel_en(vpp_accel_en),
    .drive_strength(drive_strength));
  flash_cfg_monitor i_flash_cfg_monitor (.clock(clock), .reset_n(reset_n),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

  // Memory content is a scramble of the address, so a shifted byte shows.
  assign mem_data = mem_addr[7:0] ^ 8'hA5;

  // Clock of 100 ns period.
  initial begin
    forever #50 clock = ~clock;
  end

  // Every finished APB access is held against the oldest note.
  always @(posedge clock) begin
    if (psel && penable && pready) begin
      note = notes.pop_front();
      `CHK({pslverr, prdata} & note[32:0], note[65:33] & note[32:0])
    end
  end

  // A hung handshake ends the run instead of stalling it.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Four bytes a fast read should return, last byte lowest.
  function automatic logic [31:0] wrap_bytes(input logic [23:0] a,
      input logic [1:0] w);
    logic [31:0] r;
    logic [23:0] s;
    logic [23:0] b;
    r = 32'h0;
    s = 24'd16 << w;
    for (int k = 0; k < 4; k++) begin
      b = (w == 2'h3) ? a + 24'(k) : (a & ~(s - 24'd1)) |
        ((a + 24'(k)) & (s - 24'd1));
      r = {r[23:0], b[7:0] ^ 8'hA5};
    end
    return r;
  endfunction

  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; the expected {error, data} is noted at setup.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e, input logic [32:0] m,
      output logic [31:0] r);
    @(posedge clock);
    notes.push_back({e, m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle();
    logic [31:0] r;
    r = 32'h1;
    while (r[0] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0, 33'h0, M_ERR, r);
  endtask

  // A whole frame: data, command, wait, then the received bytes.
  task automatic frame(input logic [7:0] op, input logic noop,
      input logic [1:0] ntx, input logic [2:0] nrx, input logic [3:0] dum,
      input logic [23:0] tx, input logic [31:0] e);
    logic [31:0] r;
    logic [31:0] m;
    m = 32'hFFFFFFFF >> (32 - 8 * int'(nrx));
    apb(1'b1, REG_TXDATA, {8'h00, tx}, 33'h0, M_ERR, r);
    apb(1'b1, REG_CMD, {14'h0, dum, nrx, ntx, noop, op}, 33'h0, M_ERR, r);
    wait_idle();
    if (nrx != 3'd0) apb(1'b0, REG_RXDATA, 32'h0, {1'b0, e}, {1'b1, m}, r);
  endtask

  task automatic rd_reg(input logic [7:0] op, input logic [2:0] n,
      input logic [31:0] e);
    frame(op, 1'b0, 2'd0, n, 4'h0, 24'h0, e);
  endtask

  task automatic chk_out(input logic [7:0] v, input logic [7:0] ev);
    logic [3:0] dc;
    protocol_t p;
    dc = (v[7:4] == 4'h0 || v[7:4] == 4'hF) ? 4'hA : v[7:4];
    p = !ev[7] ? PROTO_QUAD : (!ev[6] ? PROTO_DUAL : PROTO_EXTENDED);
    `CHK(dummy_cycles, dc)
    `CHK(execute_in_place, ~v[3])
    `CHK(wrap_code, v[1:0])
    `CHK(protocol, p)
    `CHK(hold_reset_en, ev[4])
    `CHK(vpp_accel_en, ~ev[3])
    `CHK(drive_strength, ev[2:0])
  endtask

  // Writes both registers, checks the outputs at once, reads them back.
  task automatic set_regs(input logic [7:0] v, input logic [7:0] ev);
    frame(OP_WRITE_VCR, 1'b0, 2'd1, 3'd0, 4'h0, {v, 16'h0}, 32'h0);
    frame(OP_WRITE_EVCR, 1'b0, 2'd1, 3'd0, 4'h0, {ev, 16'h0}, 32'h0);
    chk_out(v, ev);
    rd_reg(OP_READ_VCR, 3'd1, {24'h0, v & VCR_MASK});
    rd_reg(OP_READ_EVCR, 3'd1, {24'h0, ev & EVCR_MASK});
  endtask

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic [31:0] e;
    logic [3:0] codes[6] = '{4'h0, 4'hF, 4'h1, 4'hE, 4'h7, 4'hA};
    logic [7:0] evs[6] = '{8'h3F, 8'h7F, 8'hBF, 8'hFF, 8'h00, 8'h00};
    logic [23:0] addrs[4] = '{24'h10E, 24'h21E, 24'h33E, 24'h44E};
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    chk_out(VCR_RESET, EVCR_RESET);
    rd_reg(OP_READ_NV, 3'd2, {16'h0, NV_RESET});
    foreach (codes[i]) begin
      seed = xs(seed);
      set_regs({codes[i], seed[3:0]}, (i < 4) ? evs[i] : seed[15:8]);
    end
    // Unmapped places and a command written while busy are refused.
    apb(1'b0, 8'h10, 32'h0, M_ERR, {1'b1, 32'hFFFFFFFF}, r);
    apb(1'b1, 8'h14, 32'h0, M_ERR, M_ERR, r);
    apb(1'b1, REG_CMD, {18'h0, 3'd1, 11'h0} | 32'(OP_READ_VCR), 33'h0,
      M_ERR, r);
    apb(1'b1, REG_CMD, 32'h0, M_ERR, M_ERR, r);
    wait_idle();
    // An unknown command is ignored and returns nothing but zeros.
    rd_reg(8'h3C, 3'd1, 32'h0);
    // Each wrap code, started near the end of its block.
    foreach (addrs[i]) begin
      set_regs({4'h2, 2'b10, 2'(i)}, 8'hFF);
      frame(OP_FAST_READ, 1'b0, 2'd3, 3'd4, 4'h2, addrs[i],
        wrap_bytes(addrs[i], 2'(i)));
    end
    // Execute in place: the next frame carries no command byte.
    set_regs(8'h23, 8'hFF);
    e = wrap_bytes(24'h100, 2'h3);
    frame(OP_FAST_READ, 1'b0, 2'd3, 3'd2, 4'h2, 24'h100, e >> 16);
    e = wrap_bytes(24'h200, 2'h3);
    frame(8'h00, 1'b1, 2'd3, 3'd2, 4'h2, 24'h200, e >> 16);
    frame(8'h00, 1'b1, 2'd1, 3'd0, 4'h0, 24'h0, 32'h0);
    // Nonvolatile protocol bits wait for the next power-on.
    frame(OP_WRITE_NV, 1'b0, 2'd2, 3'd0, 4'h0, 24'h3FD000, 32'h0);
    `CHK(protocol, PROTO_EXTENDED)
    power_cycle <= 1'b1;
    repeat (4) @(posedge clock);
    power_cycle <= 1'b0;
    rd_reg(OP_READ_NV, 3'd2, 32'h3FD0);
    rd_reg(OP_READ_VCR, 3'd1, 32'h3B);
    rd_reg(OP_READ_EVCR, 3'd1, 32'h1F);
    chk_out(8'h3B, 8'h1F);
    close_out();
  end
endmodule
